// ### hw/hpac_master.sv
// Controller end: writes one command byte per request over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module hpac_master (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   hpac_if.master          bus,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   output var  logic       cmd_ready,
   output var  logic       done,
   output var  logic       nack
);
   // ==========================================
   // Bit-level sequencer
   typedef enum logic [5:0] {
      M_IDLE  = 6'b000001,
      M_START = 6'b000010,
      M_BIT   = 6'b000100,
      M_ACK   = 6'b001000,
      M_STOP  = 6'b010000,
      M_END   = 6'b100000
   } hpac_mst_type;
   hpac_mst_type state, next_state;
   logic [7:0] tick_cnt, next_tick_cnt;
   logic [1:0] phase, next_phase;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] sh, next_sh, data_q, next_data_q;
   logic       on_data, next_on_data;
   logic       scl_r, next_scl_r, sda_oe, next_sda_oe;
   logic       ready_r, next_ready_r, done_r, next_done_r, nack_r, next_nack_r;
   logic       tick;
   // Quarter-bit enable keeps the bus at or below 400kHz
   assign tick = (tick_cnt == 8'((hpac_pkg::SCL_HALF_CYC + 1) / 2 - 1));
   always_comb begin
      next_state    = state;
      next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
      next_phase    = phase;
      next_bitcnt   = bitcnt;
      next_sh       = sh;
      next_data_q   = data_q;
      next_on_data  = on_data;
      next_scl_r    = scl_r;
      next_sda_oe   = sda_oe;
      next_ready_r  = 1'b0;
      next_done_r   = 1'b0;
      next_nack_r   = nack_r;
      unique case (state)
         M_IDLE: begin
            next_ready_r = 1'b1;
            next_scl_r   = 1'b1;
            next_sda_oe  = 1'b0;
            if (cmd_valid && ready_r) begin
               next_ready_r = 1'b0;
               next_data_q  = cmd_byte;
               next_sh      = {hpac_pkg::DEV_ADDR, 1'b0};
               next_on_data = 1'b0;
               next_nack_r  = 1'b0;
               next_phase   = 2'h0;
               next_state   = M_START;
            end
         end
         M_START: if (tick) begin
            next_sda_oe = 1'b1;
            next_bitcnt = 4'h0;
            next_state  = M_BIT;
            next_phase  = 2'h0;
         end
         M_BIT, M_ACK: if (tick) begin
            next_phase = phase + 2'h1;
            unique case (phase)
               2'h0: next_scl_r = 1'b0;
               // Change data only while clock is low
               2'h1: next_sda_oe = (state == M_BIT) ? ~sh[7] : 1'b0;
               2'h2: next_scl_r = 1'b1;
               2'h3: begin
                  if (state == M_BIT) begin
                     next_sh     = {sh[6:0], 1'b0};
                     next_bitcnt = bitcnt + 4'h1;
                     if (bitcnt == 4'h7) begin
                        next_state = M_ACK;
                     end
                  end else if (bus.sda) begin
                     next_nack_r = 1'b1;
                     next_state  = M_STOP;
                  end else if (!on_data) begin
                     next_on_data = 1'b1;
                     next_sh      = data_q;
                     next_bitcnt  = 4'h0;
                     next_state   = M_BIT;
                  end else begin
                     next_state = M_STOP;
                  end
               end
            endcase
         end
         M_STOP: if (tick) begin
            next_phase = phase + 2'h1;
            unique case (phase)
               2'h0: next_scl_r = 1'b0;
               2'h1: next_sda_oe = 1'b1;
               2'h2: next_scl_r = 1'b1;
               2'h3: begin
                  next_sda_oe = 1'b0;
                  next_state  = M_END;
               end
            endcase
         end
         M_END: if (tick) begin
            next_done_r = 1'b1;
            next_state  = M_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= M_IDLE;
         tick_cnt <= 8'h00;
         phase    <= 2'h0;
         bitcnt   <= 4'h0;
         sh       <= 8'h00;
         data_q   <= 8'h00;
         on_data  <= 1'b0;
         scl_r    <= 1'b1;
         sda_oe   <= 1'b0;
         ready_r  <= 1'b0;
         done_r   <= 1'b0;
         nack_r   <= 1'b0;
      end else begin
         state    <= next_state;
         tick_cnt <= next_tick_cnt;
         phase    <= next_phase;
         bitcnt   <= next_bitcnt;
         sh       <= next_sh;
         data_q   <= next_data_q;
         on_data  <= next_on_data;
         scl_r    <= next_scl_r;
         sda_oe   <= next_sda_oe;
         ready_r  <= next_ready_r;
         done_r   <= next_done_r;
         nack_r   <= next_nack_r;
      end
   end
   assign bus.scl      = scl_r;
   assign bus.sda_m_oe = sda_oe;
   assign cmd_ready    = ready_r;
   assign done         = done_r;
   assign nack         = nack_r;
endmodule : hpac_master
`default_nettype wire

// ### hw/hpac_slave.sv
// Amplifier control slave: bus receiver, command decode, mode and load logic
`timescale 1ns/1ps
`default_nettype none
module hpac_slave #(
   parameter int DEBOUNCE_CYC = hpac_pkg::DEBOUNCE_CYC
) (
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   hpac_if.slave                   bus,
   input  wire logic               headphone_sense_pin,
   input  wire logic               power_up_evt,
   input  wire logic               thermal_recover_evt,
   input  wire logic               left_short,
   input  wire logic               right_short,
   output var  logic               mute_bit,
   output var  logic [4:0]         gain_code,
   output var  logic signed [7:0]  gain_db,
   output var  hpac_pkg::hpac_power_type power_mode,
   output var  logic               left_amp_on,
   output var  logic               right_amp_on,
   output var  logic               mono_mix,
   output var  logic               detect_run
);
   // ==========================================
   // Bus receiver
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ADDR = 4'b0010,
      S_DATA = 4'b0100,
      S_ACK  = 4'b1000
   } hpac_rx_type;
   hpac_rx_type state, next_state;
   logic       scl_q, sda_q, next_scl_q, next_sda_q;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic       ack_oe, next_ack_oe;
   logic       addr_ok, next_addr_ok;
   logic [3:0] mode_reg, next_mode_reg;
   logic [4:0] gain_reg, next_gain_reg;
   logic       scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] byte_in;
   assign scl_rise = bus.scl & ~scl_q;
   assign scl_fall = ~bus.scl & scl_q;
   assign start_c  = bus.scl & scl_q & sda_q & ~bus.sda;
   assign stop_c   = bus.scl & scl_q & ~sda_q & bus.sda;
   assign byte_in  = {shreg[6:0], bus.sda};
   always_comb begin
      next_state    = state;
      next_shreg    = shreg;
      next_bitcnt   = bitcnt;
      next_ack_oe   = ack_oe;
      next_addr_ok  = addr_ok;
      next_mode_reg = mode_reg;
      next_gain_reg = gain_reg;
      next_scl_q    = bus.scl;
      next_sda_q    = bus.sda;
      if (start_c) begin
         next_state  = S_ADDR;
         next_bitcnt = 4'h0;
         next_ack_oe = 1'b0;
      end else if (stop_c) begin
         next_state  = S_IDLE;
         next_ack_oe = 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               next_ack_oe = 1'b0;
            end
            S_ADDR, S_DATA: begin
               if (scl_rise) begin
                  next_shreg  = byte_in;
                  next_bitcnt = bitcnt + 4'h1;
                  if (bitcnt == 4'h7) begin
                     if (state == S_ADDR) begin
                        next_addr_ok = (byte_in == {hpac_pkg::DEV_ADDR, 1'b0});
                     end else begin
                        if (byte_in[7:4] == hpac_pkg::MODE_PREFIX) begin
                           next_mode_reg = byte_in[3:0];
                        end else if (byte_in[7:5] == hpac_pkg::GAIN_PREFIX) begin
                           next_gain_reg = byte_in[4:0];
                        end
                     end
                  end
               end
               if (scl_fall && bitcnt == 4'h8) begin
                  next_state  = S_ACK;
                  // The write bit was already folded into the match; the live line may have moved on
                  next_ack_oe = (state == S_DATA) | addr_ok;
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  next_ack_oe = 1'b0;
                  next_bitcnt = 4'h0;
                  // Unmatched address: ignore everything until the next start
                  next_state  = addr_ok ? S_DATA : S_IDLE;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= S_IDLE;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         shreg    <= 8'h00;
         bitcnt   <= 4'h0;
         ack_oe   <= 1'b0;
         addr_ok  <= 1'b0;
         mode_reg <= hpac_pkg::MODE_RESET;
         gain_reg <= hpac_pkg::GAIN_RESET;
      end else begin
         state    <= next_state;
         scl_q    <= next_scl_q;
         sda_q    <= next_sda_q;
         shreg    <= next_shreg;
         bitcnt   <= next_bitcnt;
         ack_oe   <= next_ack_oe;
         addr_ok  <= next_addr_ok;
         mode_reg <= next_mode_reg;
         gain_reg <= next_gain_reg;
      end
   end
   // Only ever pulls low for acknowledge, never read data
   assign bus.sda_s_oe = ack_oe;
   // ==========================================
   // Headphone sense debounce and load detection
   logic [23:0] db_cnt, next_db_cnt;
   logic        hp_stable, next_hp_stable;
   logic        det_busy, next_det_busy;
   logic        lshort, next_lshort, rshort, next_rshort;
   logic        run_bit, autodetect_enable_bit, stereo_select_bit, eff_stereo;
   assign run_bit               = mode_reg[hpac_pkg::RUN_POS];
   assign stereo_select_bit     = mode_reg[hpac_pkg::STEREO_POS];
   assign autodetect_enable_bit = mode_reg[hpac_pkg::AUTODETECT_POS];
   always_comb begin
      next_db_cnt    = db_cnt;
      next_hp_stable = hp_stable;
      next_det_busy  = 1'b0;
      next_lshort    = lshort;
      next_rshort    = rshort;
      if (headphone_sense_pin == hp_stable) begin
         next_db_cnt = 24'h000000;
      end else if (db_cnt == 24'(DEBOUNCE_CYC - 1)) begin
         next_db_cnt    = 24'h000000;
         next_hp_stable = headphone_sense_pin;
      end else begin
         next_db_cnt = db_cnt + 24'h000001;
      end
      // One-cycle measurement pulse; analog gives short verdicts
      // Insertion is taken from the debounced level so contact bounce cannot retrigger
      if (autodetect_enable_bit &&
          (((power_up_evt || thermal_recover_evt) && hp_stable) || (next_hp_stable && !hp_stable))) begin
         next_det_busy = 1'b1;
      end
      if (det_busy) begin
         next_lshort = left_short;
         next_rshort = right_short;
      end
      if (!autodetect_enable_bit) begin
         next_lshort = 1'b0;
         next_rshort = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         db_cnt    <= 24'h000000;
         hp_stable <= 1'b0;
         det_busy  <= 1'b0;
         lshort    <= 1'b0;
         rshort    <= 1'b0;
      end else begin
         db_cnt    <= next_db_cnt;
         hp_stable <= next_hp_stable;
         det_busy  <= next_det_busy;
         lshort    <= next_lshort;
         rshort    <= next_rshort;
      end
   end
   // ==========================================
   // Registered outputs
   hpac_pkg::hpac_power_type next_power;
   always_comb begin
      eff_stereo = stereo_select_bit & ~rshort;
      if (!run_bit) begin
         next_power = hpac_pkg::HPAC_MICRO_SD;
      end else if (hp_stable) begin
         next_power = hpac_pkg::HPAC_FULL;
      end else begin
         next_power = hpac_pkg::HPAC_STANDBY;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mute_bit     <= 1'b0;
         gain_code    <= hpac_pkg::GAIN_RESET;
         gain_db      <= hpac_pkg::gain_db(hpac_pkg::GAIN_RESET);
         power_mode   <= hpac_pkg::HPAC_MICRO_SD;
         left_amp_on  <= 1'b0;
         right_amp_on <= 1'b0;
         mono_mix     <= 1'b1;
         detect_run   <= 1'b0;
      end else begin
         mute_bit     <= mode_reg[hpac_pkg::MUTE_POS];
         gain_code    <= gain_reg;
         gain_db      <= hpac_pkg::gain_db(gain_reg);
         power_mode   <= next_power;
         // Left short kills both amplifiers for protection
         left_amp_on  <= (next_power == hpac_pkg::HPAC_FULL) & ~lshort;
         right_amp_on <= (next_power == hpac_pkg::HPAC_FULL) & ~lshort & eff_stereo;
         mono_mix     <= ~eff_stereo;
         detect_run   <= det_busy;
      end
   end
endmodule : hpac_slave
`default_nettype wire

// ### inc/hpac_if.sv
// Two-wire bus between controller and amplifier control slave
`timescale 1ns/1ps
`default_nettype none
interface hpac_if;
   logic scl;
   logic sda_m_oe;
   logic sda_s_oe;
   logic sda;
   // Open drain with pull-up: low when either end drives
   assign sda = ~(sda_m_oe | sda_s_oe);
   modport master (output scl, output sda_m_oe, input sda);
   modport slave  (input scl, output sda_s_oe, input sda);
endinterface : hpac_if
`default_nettype wire

// ### inc/hpac_pkg.sv
// Shared constants and types for the headphone amplifier serial control link
package hpac_pkg;
   // ==========================================
   // Addressing and command decode
   localparam logic [6:0] DEV_ADDR        = 7'h76;
   localparam logic [3:0] MODE_PREFIX     = 4'h0;
   localparam logic [2:0] GAIN_PREFIX     = 3'h4;
   localparam int         AUTODETECT_POS  = 3;
   localparam int         MUTE_POS        = 2;
   localparam int         STEREO_POS      = 1;
   localparam int         RUN_POS         = 0;
   localparam logic [3:0] MODE_RESET      = 4'h0;
   localparam logic [4:0] GAIN_RESET      = 5'h00;
   // ==========================================
   // Timing
   localparam int CLK_HZ          = 25000000;
   localparam int SCL_MAX_HZ      = 400000;
   localparam int SCL_HALF_CYC    = (CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
   localparam int DEBOUNCE_MS     = 200;
   localparam int DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
   // ==========================================
   // Operating modes
   typedef enum logic [2:0] {
      HPAC_MICRO_SD = 3'b001,
      HPAC_STANDBY  = 3'b010,
      HPAC_FULL     = 3'b100
   } hpac_power_type;
   // Gain in dB for each code
   function automatic logic signed [7:0] gain_db(input logic [4:0] code);
      logic signed [7:0] tab [0:31];
      tab = '{-8'sd70, -8'sd60, -8'sd52, -8'sd44, -8'sd38, -8'sd34, -8'sd30, -8'sd27,
              -8'sd24, -8'sd21, -8'sd18, -8'sd16, -8'sd14, -8'sd12, -8'sd10, -8'sd8,
              -8'sd6, -8'sd4, -8'sd2, 8'sd0, 8'sd2, 8'sd4, 8'sd6, 8'sd8,
              8'sd10, 8'sd12, 8'sd13, 8'sd14, 8'sd15, 8'sd16, 8'sd17, 8'sd18};
      return tab[code];
   endfunction : gain_db
endpackage : hpac_pkg

// ### sim/hpac_monitor.sv
// Checker for the two-wire bus between the controller end and the slave
`timescale 1ns/1ps
`default_nettype none
module hpac_monitor (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic sda
);
   // 2.5 us at 40 ns a cycle, rounded down; per holds the full cycle count between rises
   localparam int PER_MIN = 62;
   logic [7:0] per;
   logic [3:0] nbit;
   logic       scl_q;
   logic       sda_q;
   // ==========================================
   // Bit slot since start and clock period
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         per   <= 8'hFF;
         nbit  <= 4'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (scl && !scl_q) begin
            per  <= 8'h01;
            nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
         end else begin
            per <= (per == 8'hFF) ? per : per + 8'h01;
            if (scl && scl_q && sda_q && !sda) begin
               nbit <= 4'h0;
            end
         end
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_ack_slot; scl && !scl_q && sda_s_oe |-> nbit == 4'h8; endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("slave drives outside ack slot");
   property p_ack_given; scl && !scl_q && nbit == 4'h8 |-> sda_s_oe && !sda_m_oe; endproperty
   a_ack_given: assert property (p_ack_given) else $error("ack slot not answered");
   property p_ack_hold; scl && !scl_q && sda_s_oe |=> sda_s_oe [*8]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack released while clock high");
   property p_s_low; $changed(sda_s_oe) |-> !scl; endproperty
   a_s_low: assert property (p_s_low) else $error("slave drive changed with clock high");
   property p_setup; scl && !scl_q |-> sda_m_oe == $past(sda_m_oe, 4); endproperty
   a_setup: assert property (p_setup) else $error("data not set up before clock rise");
   property p_high; $changed(sda_m_oe) && scl && scl_q |-> $past(scl, 4) && $past(scl, 8); endproperty
   a_high: assert property (p_high) else $error("data moved near a clock edge");
   property p_period; scl && !scl_q |-> per >= PER_MIN; endproperty
   a_period: assert property (p_period) else $error("clock period too short");
   property p_idle; $rose(sda) && scl && scl_q |-> (scl && sda) [*4]; endproperty
   a_idle: assert property (p_idle) else $error("bus not idle after stop");
   property p_start; $fell(sda) && scl && scl_q |-> ##[1:300] !scl; endproperty
   a_start: assert property (p_start) else $error("no clock after start");
endmodule : hpac_monitor
`default_nettype wire

// ### sim/test_headphone_amp_i2c_control.sv
// Testbench: controller end and slave on one bus, plus a hand-driven bus to a second slave
`timescale 1ns/1ps
`default_nettype none
module test_headphone_amp_i2c_control;
   localparam int DEB = 16;
   localparam int T   = 24;
   localparam logic [7:0] DB [32] = '{8'hBA, 8'hC4, 8'hCC, 8'hD4, 8'hDA, 8'hDE, 8'hE2, 8'hE5,
      8'hE8, 8'hEB, 8'hEE, 8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE, 8'h00,
      8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12};
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_byte = 8'h00;
   logic sense = 1'b0;
   logic pwr = 1'b0;
   logic thr = 1'b0;
   logic ls = 1'b0;
   logic rs = 1'b0;
   logic cmd_ready, done, nack, mute, mono, l_on, r_on, det, mute_b;
   logic [4:0] gc, gc_b;
   logic signed [7:0] gdb;
   hpac_pkg::hpac_power_type pm;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   hpac_if u_hpac_if ();
   hpac_if u_hpac_if_bb ();
   hpac_master u_hpac_master (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_hpac_if.master), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .done(done), .nack(nack));
   hpac_slave #(.DEBOUNCE_CYC(DEB)) u_hpac_slave (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_hpac_if.slave),
      .headphone_sense_pin(sense), .power_up_evt(pwr), .thermal_recover_evt(thr), .left_short(ls),
      .right_short(rs), .mute_bit(mute), .gain_code(gc), .gain_db(gdb), .power_mode(pm), .left_amp_on(l_on),
      .right_amp_on(r_on), .mono_mix(mono), .detect_run(det));
   hpac_slave #(.DEBOUNCE_CYC(DEB)) u_hpac_slave_bb (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_hpac_if_bb.slave),
      .headphone_sense_pin(sense), .power_up_evt(pwr), .thermal_recover_evt(thr), .left_short(ls),
      .right_short(rs), .mute_bit(mute_b), .gain_code(gc_b), .gain_db(), .power_mode(), .left_amp_on(),
      .right_amp_on(), .mono_mix(), .detect_run());
   hpac_monitor u_hpac_monitor (.ref_clk(ref_clk), .arst_n(arst_n), .scl(u_hpac_if.scl),
      .sda_m_oe(u_hpac_if.sda_m_oe), .sda_s_oe(u_hpac_if.sda_s_oe), .sda(u_hpac_if.sda));
   // ==========================================
   // Compare and access tasks
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_amp(input logic [2:0] p, input logic l, input logic r, input logic mx);
      chk({5'h00, pm}, {5'h00, p}, "power mode");
      chk({7'h00, l_on}, {7'h00, l}, "left amp");
      chk({7'h00, r_on}, {7'h00, r}, "right amp");
      chk({7'h00, mono}, {7'h00, mx}, "mono mix");
   endtask : chk_amp
   task automatic wr(input logic [7:0] b);
      int i;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      do @(posedge ref_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      for (i = 0; i < 5000 && done !== 1'b1; i++) @(posedge ref_clk);
      chk({7'h00, done}, 8'h01, "transfer done");
      repeat (3) @(posedge ref_clk);
      chk({7'h00, nack}, 8'h00, "nack");
   endtask : wr
   task automatic count_det(input int n, input logic [7:0] exp);
      logic [7:0] seen;
      seen = 8'h00;
      repeat (n) begin
         @(posedge ref_clk);
         if (det === 1'b1) seen++;
      end
      chk(seen, exp, "detection runs");
   endtask : count_det
   // Hand-driven bus keeps each level for T cycles so the clock stays under 400 kHz
   task automatic bb_tick(input logic c, input logic d);
      @(posedge ref_clk);
      u_hpac_if_bb.scl      <= c;
      u_hpac_if_bb.sda_m_oe <= d;
      repeat (T - 1) @(posedge ref_clk);
   endtask : bb_tick
   task automatic bb_byte(input logic [7:0] v, input logic exp_ack);
      int i;
      for (i = 8; i >= 0; i--) begin
         bb_tick(1'b0, u_hpac_if_bb.sda_m_oe);
         bb_tick(1'b0, (i > 0) ? ~v[i - 1] : 1'b0);
         bb_tick(1'b1, u_hpac_if_bb.sda_m_oe);
      end
      chk({7'h00, ~u_hpac_if_bb.sda}, {7'h00, exp_ack}, "ack on hand bus");
   endtask : bb_byte
   task automatic bb_frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic ok);
      bb_tick(1'b1, 1'b1);
      bb_byte(a, ok);
      bb_byte(b, ok);
      bb_byte(c, ok);
      bb_tick(1'b0, u_hpac_if_bb.sda_m_oe);
      bb_tick(1'b0, 1'b1);
      bb_tick(1'b1, 1'b1);
      bb_tick(1'b1, 1'b0);
   endtask : bb_frame
   // ==========================================
   // Watchdog and test sequence
   initial begin
      #4000000;
      n_mismatch++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      int k;
      u_hpac_if_bb.scl      <= 1'b1;
      u_hpac_if_bb.sda_m_oe <= 1'b0;
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk({3'h0, gc}, 8'h00, "gain reset");
      chk_amp(3'b001, 1'b0, 1'b0, 1'b1);
      for (k = 0; k < 32; k++) begin
         wr({3'h4, k[4:0]});
         chk({3'h0, gc}, {3'h0, k[4:0]}, "gain code");
         chk(gdb, DB[k], "gain dB");
      end
      wr(8'h01);
      chk_amp(3'b010, 1'b0, 1'b0, 1'b1);
      sense <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk_amp(3'b010, 1'b0, 1'b0, 1'b1);
      repeat (40) @(posedge ref_clk);
      chk_amp(3'b100, 1'b1, 1'b0, 1'b1);
      wr(8'h03);
      chk_amp(3'b100, 1'b1, 1'b1, 1'b0);
      wr(8'h06);
      wr(8'h50);
      chk({7'h00, mute}, 8'h01, "mute");
      chk({3'h0, gc}, 8'h1F, "gain kept");
      chk_amp(3'b001, 1'b0, 1'b0, 1'b0);
      // Short levels are only taken at a detection run
      rs <= 1'b1;
      wr(8'h0B);
      chk_amp(3'b100, 1'b1, 1'b1, 1'b0);
      pwr <= 1'b1;
      @(posedge ref_clk);
      pwr <= 1'b0;
      count_det(6, 8'h01);
      chk_amp(3'b100, 1'b1, 1'b0, 1'b1);
      ls <= 1'b1;
      rs <= 1'b0;
      thr <= 1'b1;
      @(posedge ref_clk);
      thr <= 1'b0;
      count_det(6, 8'h01);
      chk_amp(3'b100, 1'b0, 1'b0, 1'b0);
      ls <= 1'b0;
      sense <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk_amp(3'b010, 1'b0, 1'b0, 1'b0);
      sense <= 1'b1;
      count_det(60, 8'h01);
      chk_amp(3'b100, 1'b1, 1'b1, 1'b0);
      rs <= 1'b1;
      wr(8'h01);
      chk_amp(3'b100, 1'b1, 1'b0, 1'b1);
      wr(8'h03);
      chk_amp(3'b100, 1'b1, 1'b1, 1'b0);
      pwr <= 1'b1;
      @(posedge ref_clk);
      pwr <= 1'b0;
      count_det(6, 8'h00);
      chk({6'h00, u_hpac_if.scl, u_hpac_if.sda}, 8'h03, "idle bus");
      bb_frame(8'hED, 8'h9F, 8'h04, 1'b0);
      bb_frame(8'hEE, 8'h9F, 8'h04, 1'b0);
      chk({3'h0, gc_b}, 8'h00, "ignored gain");
      bb_frame(8'hEC, 8'h85, 8'h06, 1'b1);
      chk({3'h0, gc_b}, 8'h05, "second gain");
      chk({7'h00, mute_b}, 8'h01, "second mute");
      stop_test();
   end
endmodule : test_headphone_amp_i2c_control
`default_nettype wire
